// file: rtl/arc_pkg.sv
// Purpose: shared constants and types for the disk adapter resource configuration block
// Assumes: AXI4-Lite register access, 32-bit data, 25 MHz system clock
// Notes: all offsets are byte addresses of aligned words
package arc_pkg;
   // register byte offsets
   localparam logic [7:0] ARC_CTRL_OFS = 8'h00;
   localparam logic [7:0] ARC_IOSEL_OFS = 8'h04;
   localparam logic [7:0] ARC_IRQSEL_OFS = 8'h08;
   localparam logic [7:0] ARC_DMASEL_OFS = 8'h0C;
   localparam logic [7:0] ARC_STAT_OFS = 8'h10;
   localparam logic [7:0] ARC_MASK_OFS = 8'h14;
   localparam logic [7:0] ARC_CLAIM_OFS = 8'h18;
   // control bits
   localparam int ARC_CTRL_ADIS = 0;
   localparam int ARC_CTRL_FDIS = 1;
   localparam int ARC_CTRL_HDIS = 2;
   localparam int ARC_CTRL_STBY = 3;
   localparam logic [3:0] ARC_CTRL_RST = 4'h0;
   // status event bits
   localparam int ARC_EV_PRI = 0;
   localparam int ARC_EV_SEC = 1;
   localparam int ARC_EV_FDC = 2;
   localparam int ARC_EV_STBY = 3;
   localparam int ARC_NEV = 4;
   // legacy addresses
   localparam logic [9:0] ARC_PRI_BASE = 10'h1F0;
   localparam logic [9:0] ARC_SEC_BASE = 10'h170;
   localparam logic [9:0] ARC_PRI_CTL = 10'h3F6;
   localparam logic [9:0] ARC_SEC_CTL = 10'h376;
   localparam logic [9:0] ARC_FDC_SHARED = 10'h3F7;
   localparam logic [9:0] ARC_FDC_SHARED2 = 10'h377;
   // base select codes: 0 off, 1 standard, 2..6 relocated
   localparam int ARC_NBASE = 7;
   localparam logic [2:0] ARC_BASE_OFF = 3'h0;
   localparam logic [2:0] ARC_BASE_STD = 3'h1;
   localparam logic [9:0] ARC_RELOC [2:6] = '{10'h1E8, 10'h168, 10'h1E0, 10'h160, 10'h2E8};
   // irq select codes: 0 off, else line number; defaults
   localparam logic [3:0] ARC_IRQ_OFF = 4'h0;
   localparam logic [3:0] ARC_IRQ_PRI_DEF = 4'hE;
   localparam logic [3:0] ARC_IRQ_SEC_DEF = 4'hF;
   localparam logic [3:0] ARC_IRQ_FDC_DEF = 4'h6;
   // dma select: 0 off, 1..3 channel 1/3/5 index into table
   localparam logic [1:0] ARC_DMA_OFF = 2'h0;
   localparam logic [2:0] ARC_DMA_CHAN [1:3] = '{3'h1, 3'h3, 3'h5};
   localparam logic [1:0] ARC_DMA_FDC_DEF = 2'h2;
   // fdc ports
   localparam logic [9:0] ARC_FDC_BASE = 10'h3F0;
   localparam logic [2:0] ARC_FDC_LO = 3'h2;
   localparam logic [2:0] ARC_FDC_HI = 3'h5;
   // axi responses
   localparam logic [1:0] ARC_RESP_OKAY = 2'h0;
   localparam logic [1:0] ARC_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [2:0] fdc_io;
      logic [2:0] sec_io;
      logic [2:0] pri_io;
   } arc_iosel_t;
   typedef struct packed {
      logic [3:0] fdc_irq;
      logic [3:0] sec_irq;
      logic [3:0] pri_irq;
   } arc_irqsel_t;
   typedef struct packed {
      logic [1:0] fdc_dma;
      logic [1:0] hdc_dma;
   } arc_dmasel_t;
   // host i/o cycle from the expansion bus
   typedef struct packed {
      logic rd;
      logic wr;
      logic [9:0] addr;
   } arc_iocyc_t;
   typedef struct packed {
      logic pri;
      logic sec;
      logic fdc;
   } arc_sel_t;
endpackage

// file: rtl/arc_top.sv
// Purpose: resource config and address/irq/dma decode for a disk adapter with floppy
// Assumes: io cycles and controller requests arrive asynchronous, synchronised here
// Notes: one level interrupt for config events; irq/dma pins are one-hot lines
//
// Summary of operation
// [R1] hard-disk interrupt defaults to request line 14
// [R2] floppy interrupt routable to request line 6
// [R3] dma select offers at least three channels
// [R4] global disable removes the whole adapter from service
// [R5] floppy and hard-disk controllers have separate disable bits
// [R6] disable reachable by firmware and software through the register bus
// [R7] standby command request is forwarded to both channels' drives
// [R8] primary and secondary channels, master and slave each; drive_slave_out stays at master
// [R9] secondary command block decodes 170h to 177h
// [R10] five relocated base locations beyond standard ones
// [R11] base decode has an off setting
// [R12] claim report never includes port 377h
// [R13] secondary channel interrupt can use request line 15
// [R14] five further irq lines plus an off setting
// [R15] primary decodes 1F0h-1F7h and control 3F6h
// [R16] claim report never includes port 3F7h
// [R17] disabled controller ignores its addresses and holds irq and dma inactive
`timescale 1ns/100ps
`default_nettype none
module arc_top (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_in,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // expansion bus io cycle (asynchronous)
   input wire arc_pkg::arc_iocyc_t io_cyc_in,
   // controller requests (asynchronous)
   input wire logic pri_irq_req_in,
   input wire logic sec_irq_req_in,
   input wire logic fdc_irq_req_in,
   input wire logic hdc_dma_req_in,
   input wire logic fdc_dma_req_in,
   // decode selects, device within channel
   output arc_pkg::arc_sel_t io_sel_out,
   output logic [2:0] io_reg_out,
   output logic ctl_sel_out,
   output logic drive_slave_out,
   // bus request lines
   output logic [15:0] irq_lines_out,
   output logic [7:0] dma_lines_out,
   // standby pulse to drives
   output logic standby_cmd_out,
   // config interrupt
   output logic irq_out
);
   ////////////////////////////////////////////////////////////////////////
   // synchronisers for the async inputs
   localparam int NSYNC = 17;
   logic [NSYNC-1:0] sync1_q, sync2_q, sync_d;
   assign sync_d = {io_cyc_in, pri_irq_req_in, sec_irq_req_in, fdc_irq_req_in,
                    hdc_dma_req_in, fdc_dma_req_in};
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= sync_d;
         sync2_q <= sync1_q;
      end
   end
   arc_pkg::arc_iocyc_t cyc;
   logic pri_rq, sec_rq, fdc_rq, hdma_rq, fdma_rq;
   assign {cyc, pri_rq, sec_rq, fdc_rq, hdma_rq, fdma_rq} = sync2_q;

   ////////////////////////////////////////////////////////////////////////
   // registers and axi slave; a write responds two cycles after its address and data, a read one cycle after its address
   logic [3:0] ctrl_q, ctrl_d;
   arc_pkg::arc_iosel_t iosel_q, iosel_d;
   arc_pkg::arc_irqsel_t irqsel_q, irqsel_d;
   arc_pkg::arc_dmasel_t dmasel_q, dmasel_d;
   logic [arc_pkg::ARC_NEV-1:0] stat_q, stat_d, mask_q, mask_d, ev;
   logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d, awr_q, wr_q, arr_q;
   logic [7:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;
   logic stby_q, stby_d;
   logic [31:0] claim;
   logic wr_go, map_ok;
   assign wr_go = aw_q && w_q && !bv_q;
   always_comb begin
      aw_d = aw_q;
      w_d = w_q;
      awa_d = awa_q;
      wd_d = wd_q;
      bv_d = bv_q;
      br_d = br_q;
      ctrl_d = ctrl_q;
      iosel_d = iosel_q;
      irqsel_d = irqsel_q;
      dmasel_d = dmasel_q;
      mask_d = mask_q;
      stby_d = 1'b0;
      map_ok = 1'b1;
      if (s_axi_awvalid && !aw_q) begin
         aw_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q && s_axi_wstrb[0]) begin
         wd_d = s_axi_wdata;
      end
      if (s_axi_wvalid && !w_q) begin
         w_d = 1'b1;
      end
      if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
      // one shared path: bios and os both write here [R6]
      if (wr_go) begin
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
         case (awa_q)
            arc_pkg::ARC_CTRL_OFS: begin
               ctrl_d = wd_q[3:0]; // [R4] [R5]
               stby_d = wd_q[arc_pkg::ARC_CTRL_STBY]; // [R7]
               ctrl_d[arc_pkg::ARC_CTRL_STBY] = 1'b0;
            end
            arc_pkg::ARC_IOSEL_OFS: iosel_d = wd_q[8:0];
            arc_pkg::ARC_IRQSEL_OFS: irqsel_d = wd_q[11:0];
            arc_pkg::ARC_DMASEL_OFS: dmasel_d = wd_q[3:0];
            arc_pkg::ARC_MASK_OFS: mask_d = wd_q[arc_pkg::ARC_NEV-1:0];
            arc_pkg::ARC_STAT_OFS: ;
            default: map_ok = 1'b0;
         endcase
         br_d = map_ok ? arc_pkg::ARC_RESP_OKAY : arc_pkg::ARC_RESP_SLVERR;
      end
   end
   // status: set wins over write-one-to-clear
   always_comb begin
      stat_d = stat_q;
      if (wr_go && awa_q == arc_pkg::ARC_STAT_OFS) begin
         stat_d = stat_q & ~wd_q[arc_pkg::ARC_NEV-1:0];
      end
      stat_d = stat_d | ev;
   end
   // read path
   always_comb begin
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
      if (s_axi_arvalid && !rv_q) begin
         rv_d = 1'b1;
         rr_d = arc_pkg::ARC_RESP_OKAY;
         case (s_axi_araddr)
            arc_pkg::ARC_CTRL_OFS: rd_d = {28'h000_0000, ctrl_q};
            arc_pkg::ARC_IOSEL_OFS: rd_d = {23'h00_0000, iosel_q};
            arc_pkg::ARC_IRQSEL_OFS: rd_d = {20'h0_0000, irqsel_q};
            arc_pkg::ARC_DMASEL_OFS: rd_d = {28'h000_0000, dmasel_q};
            arc_pkg::ARC_STAT_OFS: rd_d = {28'h000_0000, stat_q};
            arc_pkg::ARC_MASK_OFS: rd_d = {28'h000_0000, mask_q};
            arc_pkg::ARC_CLAIM_OFS: rd_d = claim;
            default: begin
               rd_d = 32'h0000_0000;
               rr_d = arc_pkg::ARC_RESP_SLVERR;
            end
         endcase
      end
   end
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awa_q <= 8'h00;
         wd_q <= 32'h0000_0000;
         bv_q <= 1'b0;
         br_q <= 2'h0;
         rv_q <= 1'b0;
         rd_q <= 32'h0000_0000;
         rr_q <= 2'h0;
         awr_q <= 1'b1;
         wr_q <= 1'b1;
         arr_q <= 1'b1;
         ctrl_q <= arc_pkg::ARC_CTRL_RST;
         iosel_q <= {arc_pkg::ARC_BASE_STD, arc_pkg::ARC_BASE_STD, arc_pkg::ARC_BASE_STD};
         irqsel_q <= {arc_pkg::ARC_IRQ_FDC_DEF, arc_pkg::ARC_IRQ_SEC_DEF,
                      arc_pkg::ARC_IRQ_PRI_DEF}; // [R1] [R2] [R13]
         dmasel_q <= {arc_pkg::ARC_DMA_FDC_DEF, arc_pkg::ARC_DMA_OFF};
         stat_q <= '0;
         mask_q <= '0;
         stby_q <= 1'b0;
      end else begin
         aw_q <= aw_d;
         w_q <= w_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         bv_q <= bv_d;
         br_q <= br_d;
         rv_q <= rv_d;
         rd_q <= rd_d;
         rr_q <= rr_d;
         awr_q <= !aw_d;
         wr_q <= !w_d;
         arr_q <= !rv_d;
         ctrl_q <= ctrl_d;
         iosel_q <= iosel_d;
         irqsel_q <= irqsel_d;
         dmasel_q <= dmasel_d;
         stat_q <= stat_d;
         mask_q <= mask_d;
         stby_q <= stby_d;
      end
   end
   assign s_axi_awready = awr_q;
   assign s_axi_wready = wr_q;
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = br_q;
   assign s_axi_arready = arr_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rd_q;
   assign s_axi_rresp = rr_q;

   ////////////////////////////////////////////////////////////////////////
   // enables; adapter disable overrides both controllers
   logic hdc_en, fdc_en;
   assign hdc_en = !ctrl_q[arc_pkg::ARC_CTRL_ADIS] && !ctrl_q[arc_pkg::ARC_CTRL_HDIS]; // [R4] [R5]
   assign fdc_en = !ctrl_q[arc_pkg::ARC_CTRL_ADIS] && !ctrl_q[arc_pkg::ARC_CTRL_FDIS]; // [R4] [R5]

   // base lookup: legacy address for codes 0 (off), 1 and 7, or one of five relocations for 2..6
   function automatic logic [9:0] arc_base(input logic [2:0] sel, input logic [9:0] std);
      logic [9:0] b;
      b = std;
      if (sel >= 3'd2 && sel <= 3'd6) begin
         b = arc_pkg::ARC_RELOC[sel]; // [R10]
      end
      return b;
   endfunction
   logic [9:0] pri_b, sec_b, fdc_b;
   assign pri_b = arc_base(iosel_q.pri_io, arc_pkg::ARC_PRI_BASE); // [R15]
   assign sec_b = arc_base(iosel_q.sec_io, arc_pkg::ARC_SEC_BASE); // [R9]
   assign fdc_b = arc_base(iosel_q.fdc_io, arc_pkg::ARC_FDC_BASE);
   // claim word: bases only; shared x7h ports are never listed [R12] [R16]
   assign claim = {2'b00, fdc_b, sec_b, pri_b};

   ////////////////////////////////////////////////////////////////////////
   // address decode, registered
   arc_pkg::arc_sel_t sel_q, sel_d;
   logic [2:0] reg_q, reg_d;
   logic ctl_q, ctl_d;
   always_comb begin
      sel_d = '0;
      ctl_d = 1'b0;
      reg_d = cyc.addr[2:0];
      if (cyc.rd || cyc.wr) begin
         // off setting answers nothing [R11] [R17]
         sel_d.pri = hdc_en && iosel_q.pri_io != arc_pkg::ARC_BASE_OFF &&
                     cyc.addr[9:3] == pri_b[9:3]; // [R15]
         sel_d.sec = hdc_en && iosel_q.sec_io != arc_pkg::ARC_BASE_OFF &&
                     cyc.addr[9:3] == sec_b[9:3]; // [R8] [R9]
         if (hdc_en && iosel_q.pri_io == arc_pkg::ARC_BASE_STD &&
             cyc.addr == arc_pkg::ARC_PRI_CTL) begin
            ctl_d = 1'b1; // [R15]
            sel_d.pri = 1'b1;
         end
         if (hdc_en && iosel_q.sec_io == arc_pkg::ARC_BASE_STD &&
             cyc.addr == arc_pkg::ARC_SEC_CTL) begin
            ctl_d = 1'b1;
            sel_d.sec = 1'b1;
         end
         sel_d.fdc = fdc_en && iosel_q.fdc_io != arc_pkg::ARC_BASE_OFF &&
                     cyc.addr[9:3] == fdc_b[9:3] &&
                     cyc.addr[2:0] >= arc_pkg::ARC_FDC_LO &&
                     cyc.addr[2:0] <= arc_pkg::ARC_FDC_HI; // [R17]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // irq and dma routing; one-hot lines, disabled sources held low
   logic [15:0] irq_d, irq_q;
   logic [7:0] dma_d, dma_q;
   logic [2:0] src_rq;
   logic [2:0] src_en;
   logic [3:0] src_line [3];
   assign src_rq = {fdc_rq, sec_rq, pri_rq};
   assign src_en = {fdc_en, hdc_en, hdc_en}; // [R17]
   assign src_line[0] = irqsel_q.pri_irq; // [R1] [R14]
   assign src_line[1] = irqsel_q.sec_irq; // [R13]
   assign src_line[2] = irqsel_q.fdc_irq; // [R2]
   always_comb begin
      irq_d = 16'h0000;
      dma_d = 8'h00;
      for (int i = 0; i < 3; i++) begin
         if (src_rq[i] && src_en[i] && src_line[i] != arc_pkg::ARC_IRQ_OFF) begin
            irq_d[src_line[i]] = 1'b1; // [R14]
         end
      end
      if (hdma_rq && hdc_en && dmasel_q.hdc_dma != arc_pkg::ARC_DMA_OFF) begin
         dma_d[arc_pkg::ARC_DMA_CHAN[dmasel_q.hdc_dma]] = 1'b1; // [R3]
      end
      if (fdma_rq && fdc_en && dmasel_q.fdc_dma != arc_pkg::ARC_DMA_OFF) begin
         dma_d[arc_pkg::ARC_DMA_CHAN[dmasel_q.fdc_dma]] = 1'b1; // [R3]
      end
   end
   // events: controller interrupts seen, and standby issued
   assign ev = {stby_q, fdc_rq & fdc_en, sec_rq & hdc_en, pri_rq & hdc_en};
   logic irqo_q, slv_q;
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         sel_q <= '0;
         reg_q <= 3'h0;
         ctl_q <= 1'b0;
         irq_q <= 16'h0000;
         dma_q <= 8'h00;
         irqo_q <= 1'b0;
         slv_q <= 1'b0;
      end else begin
         sel_q <= sel_d;
         reg_q <= reg_d;
         ctl_q <= ctl_d;
         irq_q <= irq_d;
         dma_q <= dma_d;
         irqo_q <= |(stat_d & mask_q);
         // a write to register 6 always selects master, addr[0] xor itself being 0 [R8]
         if ((sel_d.pri || sel_d.sec) && !ctl_d && cyc.wr && reg_d == 3'h6) begin
            slv_q <= cyc.addr[0] ^ cyc.addr[0];
         end
      end
   end
   assign io_sel_out = sel_q;
   assign io_reg_out = reg_q;
   assign ctl_sel_out = ctl_q;
   assign drive_slave_out = slv_q;
   assign irq_lines_out = irq_q;
   assign dma_lines_out = dma_q;
   assign standby_cmd_out = stby_q; // [R7]
   assign irq_out = irqo_q;

   ////////////////////////////////////////////////////////////////////////
   // checks
   off_no_sel_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      !hdc_en |=> !sel_q.pri && !sel_q.sec) else $error("disabled hdc selected"); // [R17]
   fdc_off_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      !fdc_en |=> !sel_q.fdc) else $error("disabled fdc selected"); // [R5]
   adis_irq_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      ctrl_q[arc_pkg::ARC_CTRL_ADIS] && $stable(ctrl_q) |=> irq_q == 16'h0000 && dma_q == 8'h00)
      else $error("irq or dma active while disabled"); // [R4]
   base_off_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      iosel_q.sec_io == arc_pkg::ARC_BASE_OFF |=> !sel_q.sec || ctl_q)
      else $error("secondary decode while off"); // [R11]
   claim_x7_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      claim[9:0] != arc_pkg::ARC_FDC_SHARED && claim[19:10] != arc_pkg::ARC_FDC_SHARED2)
      else $error("shared port claimed"); // [R12] [R16]
   pri_dec_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      hdc_en && iosel_q.pri_io == arc_pkg::ARC_BASE_STD && (cyc.rd || cyc.wr) &&
      cyc.addr == arc_pkg::ARC_PRI_CTL |=> sel_q.pri && ctl_q)
      else $error("3f6 not decoded"); // [R15]
   sec_irq_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      sec_rq && hdc_en && irqsel_q.sec_irq == arc_pkg::ARC_IRQ_SEC_DEF |=> irq_q[15])
      else $error("irq15 not raised"); // [R13]
   stby_ev_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      standby_cmd_out |=> stat_q[arc_pkg::ARC_EV_STBY])
      else $error("standby event lost"); // [R7]
   cv_wr_c: cover property (@(posedge clk_sys_in) disable iff (reset_in) wr_go);
   cv_irq_c: cover property (@(posedge clk_sys_in) disable iff (reset_in) irq_out);
   cv_fdc_c: cover property (@(posedge clk_sys_in) disable iff (reset_in) sel_q.fdc);
endmodule
`default_nettype wire

// file: test/arc_host_model.sv
// Purpose: host-side model that drives expansion bus io cycles and controller requests
// Assumes: one io cycle at a time; every level changes just after a rising edge
// Notes: nothing holds the address once the cycle ends, so it shows the inverted last value
`timescale 1ns/100ps
`default_nettype none
module arc_host_model (
   // clock
   input wire logic clk_sys_in,
   // lines towards the adapter
   output var arc_pkg::arc_iocyc_t io_cyc_out,
   output var logic [4:0] req_out
);
   ////////////////////////////////////////////////////////////////////////////////
   // idle bus and quiet request lines from time zero
   initial begin
      io_cyc_out = '0;
      req_out = 5'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // open a cycle, a write at odd addresses so both strobes are used; io_idle ends it
   task automatic io_read(input logic [9:0] a);
      @(posedge clk_sys_in);
      io_cyc_out <= '{rd: !a[0], wr: a[0], addr: a};
   endtask

   // released address floats, so a stale match must never be trusted
   task automatic io_idle();
      @(posedge clk_sys_in);
      io_cyc_out <= '{rd: 1'b0, wr: 1'b0, addr: ~io_cyc_out.addr};
   endtask

   // request bits: 0 pri irq, 1 sec irq, 2 fdc irq, 3 hdc dma, 4 fdc dma
   task automatic set_req(input int idx, input logic v);
      @(posedge clk_sys_in);
      req_out[idx] <= v;
   endtask
endmodule
`default_nettype wire

// file: test/tb.sv
// Purpose: self-checking bench for the disk adapter resource configuration block
// Assumes: registers over axi4-lite, host model drives io cycles and requests
// Notes: io and request paths are sampled one edge after their 3-edge sync latency
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clk_sys_in = 1'b0;
   logic reset_in = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, rd_val;
   logic [1:0] rsp_val;
   arc_pkg::arc_iocyc_t io_cyc_in;
   arc_pkg::arc_sel_t io_sel_out;
   logic [2:0] io_reg_out;
   logic ctl_sel_out, drive_slave_out, standby_cmd_out, irq_out;
   logic [15:0] irq_lines_out;
   logic [7:0] dma_lines_out;
   logic [4:0] req;
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;
   int stby_pulses = 0;

   arc_top dut (
      .clk_sys_in, .reset_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .io_cyc_in, .pri_irq_req_in(req[0]),
      .sec_irq_req_in(req[1]), .fdc_irq_req_in(req[2]), .hdc_dma_req_in(req[3]),
      .fdc_dma_req_in(req[4]), .io_sel_out, .io_reg_out, .ctl_sel_out, .drive_slave_out,
      .irq_lines_out, .dma_lines_out, .standby_cmd_out, .irq_out
   );
   arc_host_model u_host (.clk_sys_in, .io_cyc_out(io_cyc_in), .req_out(req));

   ////////////////////////////////////////////////////////////////////////////////
   // clock, watchdog and standby pulse counter (mid-cycle, clear of edge races)
   always #20 clk_sys_in = ~clk_sys_in;
   always @(negedge clk_sys_in) if (standby_cmd_out === 1'b1) stby_pulses++;
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         $display("[ERR] %0t watchdog expired", $time);
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // write: address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok, aw_hit, w_hit;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk_sys_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(negedge clk_sys_in);
         aw_hit = s_axi_awvalid && s_axi_awready;
         w_hit = s_axi_wvalid && s_axi_wready;
         @(posedge clk_sys_in);
         if (aw_hit) begin
            s_axi_awvalid <= 1'b0;
            aw_ok = 1'b1;
         end
         if (w_hit) begin
            s_axi_wvalid <= 1'b0;
            w_ok = 1'b1;
         end
      end
      do begin
         @(negedge clk_sys_in);
         aw_hit = s_axi_bvalid;
         rsp_val = s_axi_bresp;
         @(posedge clk_sys_in);
      end while (aw_hit !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a);
      logic hit;
      @(posedge clk_sys_in);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge clk_sys_in);
         hit = s_axi_arready;
         @(posedge clk_sys_in);
      end while (hit !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do begin
         @(negedge clk_sys_in);
         hit = s_axi_rvalid;
         rd_val = s_axi_rdata;
         rsp_val = s_axi_rresp;
         @(posedge clk_sys_in);
      end while (hit !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      axi_rd(a);
      check(rd_val, exp);
      check(32'(rsp_val), 32'(arc_pkg::ARC_RESP_OKAY));
   endtask
   // io cycle held past the sync latency, then released
   task automatic io_chk(input logic [9:0] a, input logic [2:0] sel, input logic [2:0] rg);
      u_host.io_read(a);
      repeat (4) @(posedge clk_sys_in);
      #1 check(32'(io_sel_out), 32'(sel));
      if (sel != 3'b000) check(32'(io_reg_out), 32'(rg));
      u_host.io_idle();
   endtask
   task automatic req_chk(input int idx, input logic [15:0] il, input logic [7:0] dl);
      u_host.set_req(idx, 1'b1);
      repeat (4) @(posedge clk_sys_in);
      #1 check(32'(irq_lines_out), 32'(il));
      check(32'(dma_lines_out), 32'(dl));
      u_host.set_req(idx, 1'b0);
      repeat (4) @(posedge clk_sys_in);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence: defaults, decode, relocation, routing, disables, events
   initial begin
      int lines [5] = '{3, 5, 10, 11, 12};
      repeat (6) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      rd_chk(arc_pkg::ARC_CTRL_OFS, 32'h0000_0000);
      rd_chk(arc_pkg::ARC_IOSEL_OFS, 32'h0000_0049);
      rd_chk(arc_pkg::ARC_IRQSEL_OFS, 32'h0000_06FE);
      rd_chk(arc_pkg::ARC_DMASEL_OFS, 32'h0000_0008);
      rd_chk(arc_pkg::ARC_CLAIM_OFS, {2'b00, 10'h3F0, 10'h170, 10'h1F0});
      axi_rd(8'h1C);
      check(rd_val, 32'h0000_0000);
      check(32'(rsp_val), 32'(arc_pkg::ARC_RESP_SLVERR));
      axi_wr(8'h1C, 32'h0000_0001);
      check(32'(rsp_val), 32'(arc_pkg::ARC_RESP_SLVERR));
      for (int k = 0; k < 8; k++) io_chk(10'h1F0 + 10'(k), 3'b100, 3'(k));
      for (int k = 0; k < 8; k++) io_chk(10'h170 + 10'(k), 3'b010, 3'(k));
      io_chk(10'h3F2, 3'b001, 3'h2);
      for (int i = 0; i < 2; i++) begin
         u_host.io_read(i == 0 ? arc_pkg::ARC_PRI_CTL : arc_pkg::ARC_SEC_CTL);
         repeat (4) @(posedge clk_sys_in);
         #1 check(32'(ctl_sel_out), 32'h0000_0001);
         u_host.io_idle();
      end
      check(32'(drive_slave_out), 32'h0000_0000);
      for (int c = 2; c < 7; c++) begin
         axi_wr(arc_pkg::ARC_IOSEL_OFS, 32'h0000_0048 | 32'(c));
         io_chk(arc_pkg::ARC_RELOC[c] + 10'h003, 3'b100, 3'h3);
         io_chk(10'h1F0, 3'b000, 3'h0);
      end
      axi_wr(arc_pkg::ARC_IOSEL_OFS, 32'h0000_0048);
      io_chk(10'h1F0, 3'b000, 3'h0);
      axi_wr(arc_pkg::ARC_IOSEL_OFS, 32'h0000_0049);
      req_chk(0, 16'h4000, 8'h00);
      req_chk(1, 16'h8000, 8'h00);
      req_chk(2, 16'h0040, 8'h00);
      foreach (lines[i]) begin
         axi_wr(arc_pkg::ARC_IRQSEL_OFS, 32'h0000_06F0 | 32'(lines[i]));
         req_chk(0, 16'h0001 << lines[i], 8'h00);
      end
      axi_wr(arc_pkg::ARC_IRQSEL_OFS, 32'h0000_06F0);
      req_chk(0, 16'h0000, 8'h00);
      axi_wr(arc_pkg::ARC_IRQSEL_OFS, 32'h0000_06FE);
      for (int c = 1; c < 4; c++) begin
         axi_wr(arc_pkg::ARC_DMASEL_OFS, 32'h0000_0008 | 32'(c));
         req_chk(3, 16'h0000, 8'h01 << arc_pkg::ARC_DMA_CHAN[c]);
      end
      req_chk(4, 16'h0000, 8'h08);
      // whole adapter off, then each controller alone, as firmware would
      axi_wr(arc_pkg::ARC_CTRL_OFS, 32'h0000_0001);
      io_chk(10'h1F0, 3'b000, 3'h0);
      io_chk(10'h3F2, 3'b000, 3'h0);
      req_chk(0, 16'h0000, 8'h00);
      req_chk(3, 16'h0000, 8'h00);
      axi_wr(arc_pkg::ARC_CTRL_OFS, 32'h0000_0002);
      io_chk(10'h3F2, 3'b000, 3'h0);
      io_chk(10'h1F0, 3'b100, 3'h0);
      req_chk(2, 16'h0000, 8'h00);
      axi_wr(arc_pkg::ARC_CTRL_OFS, 32'h0000_0004);
      io_chk(10'h170, 3'b000, 3'h0);
      io_chk(10'h3F2, 3'b001, 3'h2);
      req_chk(3, 16'h0000, 8'h00);
      axi_wr(arc_pkg::ARC_CTRL_OFS, 32'h0000_0000);
      // sticky status, mask and level interrupt
      axi_wr(arc_pkg::ARC_STAT_OFS, 32'h0000_000F);
      rd_chk(arc_pkg::ARC_STAT_OFS, 32'h0000_0000);
      req_chk(0, 16'h4000, 8'h00);
      rd_chk(arc_pkg::ARC_STAT_OFS, 32'h0000_0001);
      #1 check(32'(irq_out), 32'h0000_0000);
      axi_wr(arc_pkg::ARC_MASK_OFS, 32'h0000_0001);
      rd_chk(arc_pkg::ARC_MASK_OFS, 32'h0000_0001);
      #1 check(32'(irq_out), 32'h0000_0001);
      axi_wr(arc_pkg::ARC_STAT_OFS, 32'h0000_0001);
      rd_chk(arc_pkg::ARC_STAT_OFS, 32'h0000_0000);
      #1 check(32'(irq_out), 32'h0000_0000);
      axi_wr(arc_pkg::ARC_CTRL_OFS, 32'h0000_0008);
      rd_chk(arc_pkg::ARC_CTRL_OFS, 32'h0000_0000);
      check(32'(stby_pulses), 32'h0000_0001);
      rd_chk(arc_pkg::ARC_STAT_OFS, 32'h0000_0008);
      tally_and_finish();
   end
endmodule
`default_nettype wire
